//--- plc_mac_pkg.sv
package plc_mac_pkg;

	// ***************************************
	// Clock and modem timing
	// ***************************************
	localparam int unsigned CLK_HZ       = 10_000_000;
	localparam int unsigned CARRIER_HZ   = 132_500;
	localparam int unsigned BAUD_600     = 600;
	localparam int unsigned BAUD_1200    = 1200;
	localparam int unsigned BAUD_2400    = 2400;
	localparam int unsigned BAUD_4800    = 4800;
	localparam int unsigned BAUD_DIV_600  = (CLK_HZ + BAUD_600 / 2) / BAUD_600;
	localparam int unsigned BAUD_DIV_1200 = (CLK_HZ + BAUD_1200 / 2) / BAUD_1200;
	localparam int unsigned BAUD_DIV_2400 = (CLK_HZ + BAUD_2400 / 2) / BAUD_2400;
	localparam int unsigned BAUD_DIV_4800 = (CLK_HZ + BAUD_4800 / 2) / BAUD_4800;
	localparam logic [3:0]  POST_BITS    = 4'h8;

	// ***************************************
	// Register map
	// ***************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DATA   = 8'h04;
	localparam logic [7:0] REG_FLAG_A = 8'h08;
	localparam logic [7:0] REG_FLAG_B = 8'h0C;
	localparam logic [7:0] REG_MODEM  = 8'h10;
	localparam logic [7:0] REG_MARK   = 8'h14;
	localparam logic [7:0] REG_SPACE  = 8'h18;
	localparam logic [7:0] REG_FCS    = 8'h1C;

	// ***************************************
	// Field positions and reset values
	// ***************************************
	localparam int CTRL_STOP  = 0;
	localparam int CTRL_DIR   = 1;
	localparam int CTRL_WHD   = 2;
	localparam int CTRL_BYP   = 3;
	localparam int CTRL_FCS   = 4;
	localparam int CTRL_FEC   = 5;
	localparam int CTRL_TX_IRQ_ENABLE  = 6;
	localparam int CTRL_PASS_FEC_TO_HOST = 7;
	localparam int DATA_LAST  = 8;
	localparam int MODEM_DEVTX = 2;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [3:0]  MODEM_RST   = 4'h2;
	localparam logic [2:0]  HDR_CNT_RST = 3'h4;
	localparam logic [15:0] HDR_DEFAULT [4] = '{16'h9B58, 16'hE958, 16'h24E7, 16'hA5D8};
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [7:0]  FEC_MASK [6] = '{8'h5B, 8'h6D, 8'h8E, 8'hF0, 8'hB3, 8'hCC};

	typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_POST, TX_END} tx_state_t;
	typedef enum logic {RX_HUNT, RX_BYTE} rx_state_t;

	// ***************************************
	// Coding functions
	// ***************************************
	function automatic logic [5:0] fec_of(input logic [7:0] b);
		logic [5:0] f;
		f = 6'h00;
		for (int i = 0; i < 6; i++) begin
			f[i] = ^(b & FEC_MASK[i]);
		end
		return f;
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

endpackage

//--- fsk_link_if.sv
`timescale 1ns/10ps
interface fsk_link_if;
	logic [1:0]  baud_sel;
	logic        tx_deviation_select;
	logic        baud_tick;
	logic [17:0] mark_hz;
	logic [17:0] space_hz;

	modport mac (output baud_sel, output tx_deviation_select, input baud_tick, input mark_hz, input space_hz);
	modport gen (input baud_sel, input tx_deviation_select, output baud_tick, output mark_hz, output space_hz);
endinterface

//--- fsk_tone_gen.sv
`timescale 1ns/10ps
module fsk_tone_gen #(
	parameter int unsigned DIV_600 = plc_mac_pkg::BAUD_DIV_600
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	// Link to the MAC
	fsk_link_if.gen   lnk
);

	logic [14:0] div;
	logic [14:0] cnt_q;
	logic        tick_q;
	logic [12:0] baud_hz;
	logic [12:0] ofs;

	// ***************************************
	// Symbol rate divider
	// ***************************************
	always_comb begin
		case (lnk.baud_sel)
			2'h0: begin div = 15'(DIV_600); baud_hz = 13'(plc_mac_pkg::BAUD_600); end
			2'h1: begin div = 15'(plc_mac_pkg::BAUD_DIV_1200); baud_hz = 13'(plc_mac_pkg::BAUD_1200); end
			2'h2: begin div = 15'(plc_mac_pkg::BAUD_DIV_2400); baud_hz = 13'(plc_mac_pkg::BAUD_2400); end
			default: begin div = 15'(plc_mac_pkg::BAUD_DIV_4800); baud_hz = 13'(plc_mac_pkg::BAUD_4800); end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q  <= 15'h0000;
			tick_q <= 1'b0;
		end else if (cnt_q >= div - 15'h0001) begin
			cnt_q  <= 15'h0000;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 15'h0001;
			tick_q <= 1'b0;
		end
	end

	// Offset is half the rate at deviation 1, a quarter at 0.5
	assign ofs           = lnk.tx_deviation_select ? (baud_hz >> 2) : (baud_hz >> 1);
	assign lnk.mark_hz   = 18'(plc_mac_pkg::CARRIER_HZ) - {5'h00, ofs};
	assign lnk.space_hz  = 18'(plc_mac_pkg::CARRIER_HZ) + {5'h00, ofs};
	assign lnk.baud_tick = tick_q;

	// ***************************************
	// Checks
	// ***************************************
	property p_tick_single;
		@(posedge ref_clk_i) disable iff (!reset_n_i) tick_q |=> !tick_q;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("baud tick longer than one cycle");

	property p_dev1_tones;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(!lnk.tx_deviation_select && lnk.baud_sel == 2'h0) |-> (lnk.mark_hz == 18'd132200 && lnk.space_hz == 18'd132800);
	endproperty
	a_dev1_tones: assert property (p_dev1_tones) else $error("wrong tones at 600 baud");

endmodule // fsk_tone_gen

//--- plc_mac_fsk_ctrl.sv
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - A stop cycle resets MAC state and aborts any transfer in progress.
// - Four headers are matched by default, else only those programmed.
// - Headers live in an eight-byte stack selected by a two-bit index.
// - Header-write mode sends nothing to the modem; MAC holds modem direction low.
// - Header-write mode suppresses the byte-request and end interrupts regardless of enable.
// - Reset loads headers 9B58, E958, 24E7 and A5D8.
// - With check sequence on, check bytes follow the last payload byte.
// - Coding mode changes apply to the bytes that follow.
// - Byte-request and end need the enable; check-value needs check sequence mode.
// - Request when a byte fits; check value handed over; end after postamble.
// - On header match the index, then the next byte, then the interrupt follow.
// - Every received byte interrupts; FEC fields too when passing is on.
// - Coding errors set flags only; reception continues until a stop.
// - Bypass routes modem pins to the host; full mode keeps them at the MAC.
// - Rates of 600, 1200, 2400 and 4800 baud on a 132.5 kHz carrier.
// - One below the carrier, zero above, offset half or quarter of the rate.
module plc_mac_fsk_ctrl #(
	parameter int unsigned BAUD_DIV_600 = plc_mac_pkg::BAUD_DIV_600
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Modem
	input  wire logic        modem_rx_i,
	input  wire logic        carrier_detect_i,
	output logic             modem_tx_o,
	output logic             modem_dir_o,
	output logic      [17:0] tx_freq_hz_o,
	// Host port pins
	input  wire logic        host_tx_i,
	input  wire logic        host_dir_i,
	output logic             shared_rx_port_pin_o,
	output logic             carrier_detect_o,
	output logic             host_irq_line_o
);

	fsk_link_if lnk ();
	fsk_tone_gen #(.DIV_600(BAUD_DIV_600)) u_gen (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.lnk       (lnk.gen)
	);

	logic [3:0]  pin_m_q;
	logic [3:0]  pin_s_q;
	logic        pready_q, acc, wr, rd, dwr, drd, stop_q, mapped;
	logic [31:0] rdata;
	logic [7:0]  ctrl_q;
	logic [3:0]  modem_q;
	logic        dir, header_write_mode, byp, fcs_en, fec_en, tx_irq_enable, pass_fec, tx_en, rx_en, tick, rx_bit;
	logic [7:0]  hdr_q [8];
	logic [2:0]  wptr_q, hdr_cnt_q;
	logic [3:0]  hit;
	logic [1:0]  hit_idx;
	plc_mac_pkg::tx_state_t txst_q;
	plc_mac_pkg::rx_state_t rxst_q;
	logic [7:0]  hold_q;
	logic        hold_v_q, hold_last_q, tail_q, chk_q, end_q, tx_req, tx_bit;
	logic [13:0] shift_q, rsh_q;
	logic [3:0]  bits_q, post_q, rbits_q;
	logic [1:0]  pend_q, idx_q;
	logic [15:0] crc_q, fcs_val_q, win_q, rcrc_q;
	logic [7:0]  data_q;
	logic        rx_flag_q, fec_pend_q, fec_err_q, fcs_err, irq_d;
	logic [5:0]  fec_q;
	logic [13:0] rfull;

	// ***************************************
	// Pin synchronisers
	// ***************************************
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_m_q <= 4'h0;
			pin_s_q <= 4'h0;
		end else begin
			pin_m_q <= {host_dir_i, host_tx_i, carrier_detect_i, modem_rx_i};
			pin_s_q <= pin_m_q;
		end
	end

	// ***************************************
	// APB slave, one wait state
	// ***************************************
	assign acc    = psel_i & penable_i & pready_q;
	assign wr     = acc & pwrite_i;
	assign rd     = acc & ~pwrite_i;
	assign dwr    = wr && paddr_i == plc_mac_pkg::REG_DATA;
	assign drd    = rd && paddr_i == plc_mac_pkg::REG_DATA;
	assign mapped = paddr_i[1:0] == 2'h0 && paddr_i[7:5] == 3'h0;

	always_comb begin
		rdata = 32'h0000_0000;
		if (paddr_i == plc_mac_pkg::REG_CTRL) begin
			rdata = {24'h00_0000, ctrl_q};
		end else if (paddr_i == plc_mac_pkg::REG_DATA) begin
			rdata = {24'h00_0000, data_q};
		end else if (paddr_i == plc_mac_pkg::REG_FLAG_A) begin
			rdata = {30'h0000_0000, tx_req, dir ? chk_q : rx_flag_q};
		end else if (paddr_i == plc_mac_pkg::REG_FLAG_B) begin
			rdata = {23'h00_0000, pin_s_q[1], hdr_cnt_q, fcs_err, fec_err_q, end_q, idx_q};
		end else if (paddr_i == plc_mac_pkg::REG_MODEM) begin
			rdata = {28'h000_0000, modem_q};
		end else if (paddr_i == plc_mac_pkg::REG_MARK) begin
			rdata = {14'h0000, lnk.mark_hz};
		end else if (paddr_i == plc_mac_pkg::REG_SPACE) begin
			rdata = {14'h0000, lnk.space_hz};
		end else if (paddr_i == plc_mac_pkg::REG_FCS) begin
			rdata = {16'h0000, fcs_val_q};
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_q  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_q  <= psel_i & penable_i & ~pready_q;
			prdata_o  <= rdata;
			pslverr_o <= psel_i & penable_i & ~pready_q & ~mapped;
		end
	end
	assign pready_o = pready_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q  <= plc_mac_pkg::CTRL_RST;
			modem_q <= plc_mac_pkg::MODEM_RST;
			stop_q  <= 1'b0;
		end else begin
			stop_q <= wr && paddr_i == plc_mac_pkg::REG_CTRL && pwdata_i[plc_mac_pkg::CTRL_STOP];
			if (wr && paddr_i == plc_mac_pkg::REG_CTRL) begin
				ctrl_q <= {pwdata_i[7:1], 1'b0};
			end
			if (wr && paddr_i == plc_mac_pkg::REG_MODEM) begin
				modem_q <= pwdata_i[3:0];
			end
		end
	end

	assign dir      = ctrl_q[plc_mac_pkg::CTRL_DIR];
	assign header_write_mode      = ctrl_q[plc_mac_pkg::CTRL_WHD];
	assign byp      = ctrl_q[plc_mac_pkg::CTRL_BYP];
	assign fcs_en   = ctrl_q[plc_mac_pkg::CTRL_FCS];
	assign fec_en   = ctrl_q[plc_mac_pkg::CTRL_FEC];
	assign tx_irq_enable     = ctrl_q[plc_mac_pkg::CTRL_TX_IRQ_ENABLE];
	assign pass_fec = ctrl_q[plc_mac_pkg::CTRL_PASS_FEC_TO_HOST];
	assign tx_en    = dir & ~header_write_mode & ~byp;
	assign rx_en    = ~dir & ~header_write_mode & ~byp;
	assign tick     = lnk.baud_tick;
	assign rx_bit   = pin_s_q[0];
	assign lnk.baud_sel = modem_q[1:0];
	assign lnk.tx_deviation_select   = modem_q[plc_mac_pkg::MODEM_DEVTX];

	// ***************************************
	// Header stack, kept across stop cycles
	// ***************************************
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 4; i++) begin
				hdr_q[2*i]   <= plc_mac_pkg::HDR_DEFAULT[i][15:8];
				hdr_q[2*i+1] <= plc_mac_pkg::HDR_DEFAULT[i][7:0];
			end
			hdr_cnt_q <= plc_mac_pkg::HDR_CNT_RST;
			wptr_q    <= 3'h0;
		end else if (stop_q) begin
			wptr_q <= 3'h0;
		end else if (dwr && header_write_mode) begin
			hdr_q[wptr_q] <= pwdata_i[7:0];
			wptr_q        <= wptr_q + 3'h1;
			if (wptr_q[0]) begin
				hdr_cnt_q <= {1'b0, wptr_q[2:1]} + 3'h1;
			end
		end
	end

	generate
		for (genvar g = 0; g < 4; g++) begin : g_match
			assign hit[g] = (3'(g) < hdr_cnt_q) && win_q == {hdr_q[2*g], hdr_q[2*g+1]};
		end
	endgenerate
	assign hit_idx = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;

	// ***************************************
	// Transmit engine
	// ***************************************
	// Only a free hold register with no tail pending may ask for a byte
	assign tx_req = txst_q == plc_mac_pkg::TX_RUN && !hold_v_q && !hold_last_q
		&& !tail_q && pend_q == 2'h0;
	assign tx_bit = (txst_q == plc_mac_pkg::TX_RUN && bits_q != 4'h0) ? shift_q[13] : 1'b1;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			txst_q <= plc_mac_pkg::TX_IDLE;
			{hold_q, hold_v_q, hold_last_q, tail_q, chk_q, end_q} <= 13'h0000;
			{shift_q, bits_q, post_q, pend_q} <= 24'h00_0000;
			crc_q     <= plc_mac_pkg::CRC_INIT;
			fcs_val_q <= 16'h0000;
		end else if (stop_q) begin
			txst_q <= plc_mac_pkg::TX_IDLE;
			{hold_q, hold_v_q, hold_last_q, tail_q, chk_q, end_q} <= 13'h0000;
			{shift_q, bits_q, post_q, pend_q} <= 24'h00_0000;
			crc_q     <= plc_mac_pkg::CRC_INIT;
			fcs_val_q <= 16'h0000;
		end else begin
			if (rd && paddr_i == plc_mac_pkg::REG_FCS) begin
				chk_q <= 1'b0;
			end
			if (txst_q == plc_mac_pkg::TX_RUN && tick) begin
				if (bits_q > 4'h1) begin
					shift_q <= {shift_q[12:0], 1'b0};
					bits_q  <= bits_q - 4'h1;
				end else if (pend_q == 2'h2) begin
					shift_q <= {fcs_val_q[15:8], fec_en ? plc_mac_pkg::fec_of(fcs_val_q[15:8]) : 6'h00};
					bits_q  <= fec_en ? 4'hE : 4'h8;
					pend_q  <= 2'h1;
				end else if (pend_q == 2'h1) begin
					shift_q <= {fcs_val_q[7:0], fec_en ? plc_mac_pkg::fec_of(fcs_val_q[7:0]) : 6'h00};
					bits_q  <= fec_en ? 4'hE : 4'h8;
					pend_q  <= 2'h0;
					tail_q  <= 1'b1;
				end else if (tail_q) begin
					bits_q <= 4'h0;
					post_q <= 4'h0;
					txst_q <= plc_mac_pkg::TX_POST;
				end else if (hold_v_q) begin
					// Coding is sampled per byte, so a mode change takes the next byte
					shift_q  <= {hold_q, fec_en ? plc_mac_pkg::fec_of(hold_q) : 6'h00};
					bits_q   <= fec_en ? 4'hE : 4'h8;
					hold_v_q <= 1'b0;
					crc_q    <= plc_mac_pkg::crc_byte(crc_q, hold_q);
					if (hold_last_q && fcs_en) begin
						fcs_val_q <= plc_mac_pkg::crc_byte(crc_q, hold_q);
						chk_q     <= 1'b1;
						pend_q    <= 2'h2;
					end else if (hold_last_q) begin
						tail_q <= 1'b1;
					end
				end else begin
					bits_q <= 4'h0;
				end
			end
			if (txst_q == plc_mac_pkg::TX_POST && tick) begin
				post_q <= post_q + 4'h1;
				if (post_q == plc_mac_pkg::POST_BITS - 4'h1) begin
					txst_q <= plc_mac_pkg::TX_END;
					end_q  <= 1'b1;
				end
			end
			if (dwr && tx_en && !hold_last_q && txst_q != plc_mac_pkg::TX_END) begin
				hold_q      <= pwdata_i[7:0];
				hold_v_q    <= 1'b1;
				hold_last_q <= pwdata_i[plc_mac_pkg::DATA_LAST];
				if (txst_q == plc_mac_pkg::TX_IDLE) begin
					txst_q <= plc_mac_pkg::TX_RUN;
				end
			end
		end
	end

	// ***************************************
	// Receive engine
	// ***************************************
	// Bits are taken on the divider tick with no phase recovery
	assign rfull   = {rsh_q[12:0], rx_bit};
	assign fcs_err = fcs_en && rcrc_q != 16'h0000;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rxst_q <= plc_mac_pkg::RX_HUNT;
			{win_q, rsh_q, rbits_q, idx_q, data_q, fec_q} <= 50'h0;
			{rx_flag_q, fec_pend_q, fec_err_q} <= 3'h0;
			rcrc_q <= plc_mac_pkg::CRC_INIT;
		end else if (stop_q) begin
			rxst_q <= plc_mac_pkg::RX_HUNT;
			{win_q, rsh_q, rbits_q, idx_q, data_q, fec_q} <= 50'h0;
			{rx_flag_q, fec_pend_q, fec_err_q} <= 3'h0;
			rcrc_q <= plc_mac_pkg::CRC_INIT;
		end else begin
			if (drd && fec_pend_q) begin
				data_q     <= {2'h0, fec_q};
				fec_pend_q <= 1'b0;
			end else if (drd) begin
				rx_flag_q <= 1'b0;
			end
			if (rx_en && rxst_q == plc_mac_pkg::RX_HUNT) begin
				if (hit != 4'h0) begin
					rxst_q  <= plc_mac_pkg::RX_BYTE;
					idx_q   <= hit_idx;
					rbits_q <= fec_en ? 4'hE : 4'h8;
				end else if (tick) begin
					win_q <= {win_q[14:0], rx_bit};
				end
			end
			if (rx_en && rxst_q == plc_mac_pkg::RX_BYTE && tick) begin
				rsh_q   <= rfull;
				rbits_q <= rbits_q - 4'h1;
				if (rbits_q == 4'h1) begin
					// Set wins over a read clearing the same flag
					rx_flag_q <= 1'b1;
					rbits_q   <= fec_en ? 4'hE : 4'h8;
					data_q    <= fec_en ? rfull[13:6] : rfull[7:0];
					rcrc_q    <= plc_mac_pkg::crc_byte(rcrc_q, fec_en ? rfull[13:6] : rfull[7:0]);
					if (fec_en && plc_mac_pkg::fec_of(rfull[13:6]) != rfull[5:0]) begin
						fec_err_q <= 1'b1;
					end
					fec_q      <= rfull[5:0];
					fec_pend_q <= fec_en & pass_fec;
				end
			end
		end
	end

	// ***************************************
	// Pin steering and interrupt
	// ***************************************
	always_comb begin
		irq_d = 1'b0;
		if (!byp && dir) begin
			irq_d = (tx_irq_enable && !header_write_mode && (tx_req || end_q)) || (fcs_en && chk_q);
		end else if (!byp) begin
			irq_d = rx_flag_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{modem_tx_o, modem_dir_o, shared_rx_port_pin_o} <= 3'h1 << 2;
			{carrier_detect_o, host_irq_line_o} <= 2'h0;
			tx_freq_hz_o <= 18'h00000;
		end else begin
			modem_tx_o  <= byp ? pin_s_q[2] : (tx_en ? tx_bit : 1'b1);
			modem_dir_o <= byp ? pin_s_q[3] : tx_en;
			shared_rx_port_pin_o <= byp ? rx_bit : rx_flag_q;
			carrier_detect_o     <= byp & pin_s_q[1];
			host_irq_line_o      <= irq_d;
			tx_freq_hz_o <= (tx_en && txst_q == plc_mac_pkg::TX_RUN)
				? (tx_bit ? lnk.mark_hz : lnk.space_hz) : 18'h00000;
		end
	end

	// ***************************************
	// Checks
	// ***************************************
	property p_stop_clears;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		stop_q |=> (txst_q == plc_mac_pkg::TX_IDLE && !rx_flag_q && !end_q && wptr_q == 3'h0);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop left state");

	property p_hdr_reset;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> (hdr_cnt_q == 3'h4 && {hdr_q[0], hdr_q[1]} == 16'h9B58
			&& {hdr_q[6], hdr_q[7]} == 16'hA5D8);
	endproperty
	a_hdr_reset: assert property (p_hdr_reset) else $error("header defaults wrong");

	property p_hdr_count;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(dwr && header_write_mode && !stop_q && wptr_q == 3'h1) |=> hdr_cnt_q == 3'h1;
	endproperty
	a_hdr_count: assert property (p_hdr_count) else $error("header count not updated");

	property p_whd_quiet;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(header_write_mode && !byp) [*2] |-> (modem_tx_o && !modem_dir_o);
	endproperty
	a_whd_quiet: assert property (p_whd_quiet) else $error("modem driven in header mode");

	property p_whd_no_irq;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(header_write_mode && dir && !byp && !chk_q) |=> !host_irq_line_o;
	endproperty
	a_whd_no_irq: assert property (p_whd_no_irq) else $error("tx interrupt in header mode");

	property p_fcs_follows;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(txst_q == plc_mac_pkg::TX_RUN && tick && bits_q <= 4'h1 && pend_q == 2'h0 && !tail_q
			&& hold_v_q && hold_last_q && fcs_en && !stop_q) |=> (pend_q == 2'h2 && chk_q);
	endproperty
	a_fcs_follows: assert property (p_fcs_follows) else $error("check bytes not queued");

	property p_req_irq;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(tx_en && tx_irq_enable && tx_req) |=> host_irq_line_o;
	endproperty
	a_req_irq: assert property (p_req_irq) else $error("byte request not signalled");

	property p_rx_irq;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rx_en && $rose(rx_flag_q)) |-> ##[0:1] host_irq_line_o;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("received byte not signalled");

	property p_match_idx;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rx_en && rxst_q == plc_mac_pkg::RX_HUNT && hit != 4'h0 && !stop_q)
			|=> (idx_q == $past(hit_idx) && rxst_q == plc_mac_pkg::RX_BYTE);
	endproperty
	a_match_idx: assert property (p_match_idx) else $error("header index not set");

	property p_bypass_pin;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		byp |=> shared_rx_port_pin_o == $past(rx_bit);
	endproperty
	a_bypass_pin: assert property (p_bypass_pin) else $error("bypass pin not routed");

	c_hdr_hit: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		rx_en && hit != 4'h0);
	c_tx_end: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(end_q));
	c_chk: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(chk_q));
	c_whd_wr: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) dwr && header_write_mode);

endmodule // plc_mac_fsk_ctrl

//--- fsk_modem_model.sv
`timescale 1ns/10ps
// Modem stand-in: echoes the line back while sending; when receiving it
// plays one 24-bit frame msb first on request, idle mark otherwise
module fsk_modem_model #(
	parameter int BIT_CYC = 20
) (
	// Clock
	input  wire logic        clk_i,
	// MAC line side
	input  wire logic        tx_i,
	input  wire logic        dir_i,
	output logic             rx_o = 1'b1,
	output logic             cd_o = 1'b0,
	// Frame request from the bench
	input  wire logic        go_i,
	input  wire logic [23:0] frame_i
);
	logic [23:0] sh   = 24'hFFFFFF;
	int          left = 0;
	int          cyc  = 0;
	always @(posedge clk_i) begin
		cd_o <= dir_i;
		if (go_i && left == 0) begin
			sh   <= frame_i;
			left <= 24;
			cyc  <= 0;
		end else if (left != 0) begin
			if (cyc == BIT_CYC - 1) begin
				cyc  <= 0;
				sh   <= {sh[22:0], 1'b1};
				left <= left - 1;
			end else begin
				cyc <= cyc + 1;
			end
		end
		rx_o <= dir_i ? tx_i : ((left != 0) ? sh[23] : 1'b1);
	end
endmodule // fsk_modem_model

//--- tb_plc_mac_procedure_fsk_control.sv
`timescale 1ns/10ps
module tb_plc_mac_procedure_fsk_control;
	logic ck = 0, rn = 0, ps = 0, pe = 0, pw = 0, rx, cd, ht = 1, hd = 0, go = 0;
	logic [23:0] fr = 24'h000000;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h0, pr, r;
	logic rdy, err, mtx, mdir, shp, cdo, irq;
	logic [17:0] fq;
	int miscompares = 0, checks_done = 0;
	always #50 ck = ~ck;
	plc_mac_fsk_ctrl #(.BAUD_DIV_600(20)) plc_mac_fsk_ctrl_i (.ref_clk_i(ck), .reset_n_i(rn),
		.psel_i(ps), .penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
		.prdata_o(pr), .pready_o(rdy), .pslverr_o(err), .modem_rx_i(rx),
		.carrier_detect_i(cd), .modem_tx_o(mtx), .modem_dir_o(mdir), .tx_freq_hz_o(fq),
		.host_tx_i(ht), .host_dir_i(hd), .shared_rx_port_pin_o(shp),
		.carrier_detect_o(cdo), .host_irq_line_o(irq));
	fsk_modem_model #(.BIT_CYC(20)) fsk_modem_model_i (.clk_i(ck), .tx_i(mtx), .dir_i(mdir),
		.rx_o(rx), .cd_o(cd), .go_i(go), .frame_i(fr));
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge ck); ps <= 1; pe <= 0; pw <= w; pa <= a; pd <= d;
		@(posedge ck); pe <= 1;
		do begin @(posedge ck); n++; end while (rdy !== 1'b1 && n < 20);
		r = pr;
		if (n >= 20) chk("pready", 0, 1);
		ps <= 0; pe <= 0;
	endtask
	task automatic reset_vals();
		apb(0, 8'h00, 0); chk("ctrl", r, 0);
		apb(0, 8'h10, 0); chk("modem", r, 2);
		apb(0, 8'h0C, 0); chk("hdr count", r & 32'hE0, 32'h80);
		apb(0, 8'h20, 0); chk("slverr", {31'h0, err}, 1);
	endtask
	task automatic freqs();
		int b, dv;
		for (int i = 0; i < 8; i++) begin
			b = 600 << (i / 2); dv = i % 2;
			if (b == 600 && dv == 1) continue;
			apb(1, 8'h10, i[2:0] >> 1 | dv << 2);
			apb(0, 8'h14, 0); chk("mark", r, 132500 - b / (2 + 2 * dv));
			apb(0, 8'h18, 0); chk("space", r, 132500 + b / (2 + 2 * dv));
		end
		apb(1, 8'h10, 0);
	endtask
	task automatic hdr_write();
		apb(1, 8'h00, 8'h44);
		apb(1, 8'h04, 8'h12);
		apb(1, 8'h04, 8'h34);
		chk("dir", mdir, 0);
		chk("irq", irq, 0);
		apb(0, 8'h0C, 0); chk("hdr count", r & 32'hE0, 32'h20);
		apb(1, 8'h00, 1);
	endtask
	task automatic tx_byte();
		int n;
		apb(0, 8'h0C, 0); chk("cd", r[8], 0);
		apb(1, 8'h00, 8'h42);
		apb(1, 8'h04, 32'h1A5);
		chk("dir", mdir, 1);
		repeat (2) @(posedge ck);
		chk("freq", fq, 132200);
		n = 0;
		do begin apb(0, 8'h0C, 0); n++; end while (r[2] !== 1'b1 && n < 200);
		chk("end tx", r[2], 1);
		chk("irq", irq, 1);
		apb(1, 8'h00, 8'h43);
		apb(0, 8'h0C, 0); chk("end tx", r[2], 0);
		chk("irq", irq, 0);
	endtask
	task automatic bypass();
		apb(1, 8'h00, 8'h08);
		@(posedge ck); ht <= 0; hd <= 1;
		repeat (8) @(posedge ck);
		chk("tx pin", mtx, 0);
		chk("dir pin", mdir, 1);
		chk("cd pin", cdo, 1);
		chk("rx pin", shp, 0);
		ht <= 1; hd <= 0;
		apb(1, 8'h00, 1);
		repeat (8) @(posedge ck);
	endtask
	task automatic rx_frame();
		int n;
		@(posedge ck); go <= 1; fr <= 24'h1234C3;
		@(posedge ck); go <= 0;
		n = 0;
		do begin apb(0, 8'h08, 0); n++; end while (r[0] !== 1'b1 && n < 200);
		chk("rx flag", r[0], 1);
		chk("irq", irq, 1);
		chk("rx pin", shp, 1);
		apb(0, 8'h0C, 0); chk("hdr idx", r[1:0], 0);
		apb(0, 8'h04, 0); chk("rx data", r, 32'hC3);
		apb(1, 8'h00, 1);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ck);
		rn <= 1;
		reset_vals();
		freqs();
		hdr_write();
		tx_byte();
		bypass();
		rx_frame();
		close_out();
	end
endmodule // tb_plc_mac_procedure_fsk_control
